// *** include/pscf_params.svh ***
// offsets, field positions, reset values and timing counts of the perf-state block
`ifndef PSCF_PARAMS_SVH
`define PSCF_PARAMS_SVH
`define PSCF_IDX_REF      32'h0000_00E7
`define PSCF_IDX_DELIV    32'h0000_00E8
`define PSCF_IDX_CURRENT  32'h0000_0198
`define PSCF_IDX_TARGET   32'h0000_0199
`define PSCF_IDX_MISC     32'h0000_0110
`define PSCF_EN_BIT       16
`define PSCF_LEAF_FEAT    32'h0000_0001
`define PSCF_LEAF_POWER   32'h0000_0006
`define PSCF_FEAT_BIT     7
`define PSCF_FBK_BIT      0
`define PSCF_PT_RST       16'h0000
`define PSCF_MISC_RST     64'h0000_0000_0000_0000
`define PSCF_CNT_RST      64'h0000_0000_0000_0000
`define PSCF_CLK_NS       4
`define PSCF_STEP_NS      40
`define PSCF_STEP_CYC     ((`PSCF_STEP_NS + `PSCF_CLK_NS - 1) / `PSCF_CLK_NS)
`endif

// *** include/pscf_pkg.sv ***
// types shared by the perf-state control block
package pscf_pkg;
  typedef logic [15:0] pscf_point_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] idx;
    logic [63:0] data;
  } pscf_req_s;
  typedef enum logic [1:0] {
    PSCF_IDLE  = 2'b01,
    PSCF_DWELL = 2'b10
  } pscf_step_e;
endpackage

// *** hw/pscf_step.sv ***
// operating-point stepper: walks the point in force toward the latest target
`timescale 1ns/10ps
`default_nettype none
`include "pscf_params.svh"
module pscf_step
  import pscf_pkg::*;
#(
  parameter int unsigned DWELL = `PSCF_STEP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        enable,
  input  wire pscf_point_t target,
  output pscf_point_t      current,
  output logic             busy
);
  pscf_step_e  state_r;
  logic [15:0] dwell_r;
  pscf_point_t current_r;

  // target is sampled at every step, so a target rewritten mid-walk is followed
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r   <= PSCF_IDLE;
      dwell_r   <= 16'h0000;
      current_r <= `PSCF_PT_RST;
    end else begin
      case (state_r)
        PSCF_IDLE: begin
          if (enable && target != current_r) begin
            state_r <= PSCF_DWELL;
            dwell_r <= 16'(DWELL - 1);
          end
        end
        PSCF_DWELL: begin
          if (dwell_r != 16'h0000) begin
            dwell_r <= dwell_r - 16'h0001;
          end else begin
            state_r <= PSCF_IDLE;
            if (target > current_r) current_r <= current_r + 16'h0001;
            else if (target < current_r) current_r <= current_r - 16'h0001;
          end
        end
        default: state_r <= PSCF_IDLE;
      endcase
    end
  end

  assign current = current_r;
  assign busy    = (state_r == PSCF_DWELL);
endmodule
`default_nettype wire

// *** hw/pscf_top.sv ***
// per-processor perf-state control and hardware feedback counters
`timescale 1ns/10ps
`default_nettype none
`include "pscf_params.svh"
module pscf_top
  import pscf_pkg::*;
#(
  parameter int unsigned CNT_W = 64,
  parameter int unsigned DWELL = `PSCF_STEP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire pscf_req_s   modelReq,
  output logic [63:0]      modelRdData,
  output logic             modelRdValid,
  input  wire logic [31:0] idLeaf,
  output logic [31:0]      idEcx,
  input  wire logic        c0Active,
  input  wire logic        throttlePin,
  output pscf_point_t      operatingPoint,
  output logic             transitionBusy
);
  logic [63:0]      miscEnable_r;
  pscf_point_t      perfTarget_r;
  pscf_point_t      perfCurrent;
  logic [CNT_W-1:0] refCount_r;
  logic [CNT_W-1:0] delivCount_r;
  logic [63:0]      rdData_r;
  logic             rdValid_r;
  logic [31:0]      idEcx_r;
  logic             thrMeta_r;
  logic             thrSync_r;
  logic             refInc;
  logic             delivInc;
  logic             refWrap;
  logic             delivWrap;
  logic             anyWrap;
  logic             wrRef;
  logic             wrDeliv;

  function automatic logic hitIdx(input pscf_req_s r, input logic [31:0] idx);
    hitIdx = r.idx == idx;
  endfunction

  // throttle comes from a pin, so it is synchronised before use
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      thrMeta_r <= 1'b0;
      thrSync_r <= 1'b0;
    end else begin
      thrMeta_r <= throttlePin;
      thrSync_r <= thrMeta_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      miscEnable_r <= `PSCF_MISC_RST;
    end else if (modelReq.wr && hitIdx(modelReq, `PSCF_IDX_MISC)) begin
      miscEnable_r <= modelReq.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      perfTarget_r <= `PSCF_PT_RST;
    end else if (modelReq.wr && hitIdx(modelReq, `PSCF_IDX_TARGET)) begin
      perfTarget_r <= modelReq.data[15:0];
    end
  end

  pscf_step #(
    .DWELL (DWELL)
  ) u_step (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .enable  (miscEnable_r[`PSCF_EN_BIT]),
    .target  (perfTarget_r),
    .current (perfCurrent),
    .busy    (transitionBusy)
  );

  // reference counts every C0 cycle; delivered drops out while throttled or stepping
  assign refInc    = c0Active;
  assign delivInc  = c0Active && !thrSync_r && !transitionBusy;
  assign refWrap   = refInc && (&refCount_r);
  assign delivWrap = delivInc && (&delivCount_r);
  assign anyWrap   = refWrap || delivWrap;
  assign wrRef     = modelReq.wr && hitIdx(modelReq, `PSCF_IDX_REF);
  assign wrDeliv   = modelReq.wr && hitIdx(modelReq, `PSCF_IDX_DELIV);

  // a software load wins over the wrap clear for the addressed counter only
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      refCount_r <= CNT_W'(`PSCF_CNT_RST);
    end else if (wrRef) begin
      refCount_r <= modelReq.data[CNT_W-1:0];
    end else if (anyWrap) begin
      refCount_r <= '0;
    end else if (refInc) begin
      refCount_r <= refCount_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      delivCount_r <= CNT_W'(`PSCF_CNT_RST);
    end else if (wrDeliv) begin
      delivCount_r <= modelReq.data[CNT_W-1:0];
    end else if (anyWrap) begin
      delivCount_r <= '0;
    end else if (delivInc) begin
      delivCount_r <= delivCount_r + 1'b1;
    end
  end

  // read answer one cycle after the strobe; unmapped index reads zero
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdData_r  <= 64'h0000_0000_0000_0000;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= modelReq.rd;
      if (!modelReq.rd) rdData_r <= rdData_r;
      else if (hitIdx(modelReq, `PSCF_IDX_TARGET)) rdData_r <= {48'h0, perfTarget_r};
      else if (hitIdx(modelReq, `PSCF_IDX_CURRENT)) rdData_r <= {48'h0, perfCurrent};
      else if (hitIdx(modelReq, `PSCF_IDX_MISC)) rdData_r <= miscEnable_r;
      else if (hitIdx(modelReq, `PSCF_IDX_REF)) rdData_r <= 64'(refCount_r);
      else if (hitIdx(modelReq, `PSCF_IDX_DELIV)) rdData_r <= 64'(delivCount_r);
      else rdData_r <= 64'h0000_0000_0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      idEcx_r <= 32'h0000_0000;
    end else begin
      idEcx_r <= 32'h0000_0000;
      if (idLeaf == `PSCF_LEAF_FEAT) idEcx_r[`PSCF_FEAT_BIT] <= 1'b1;
      if (idLeaf == `PSCF_LEAF_POWER) idEcx_r[`PSCF_FBK_BIT] <= 1'b1;
    end
  end

  assign modelRdData    = rdData_r;
  assign modelRdValid   = rdValid_r;
  assign idEcx          = idEcx_r;
  assign operatingPoint = perfCurrent;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence tgtWrite;
    modelReq.wr && hitIdx(modelReq, `PSCF_IDX_TARGET);
  endsequence
  sequence tgtRead;
    modelReq.rd && hitIdx(modelReq, `PSCF_IDX_TARGET);
  endsequence

  // one started step lands after the dwell, whatever the enable does meanwhile
  localparam int ReachMax = DWELL + 1;

  target_latch_a: assert property (
    tgtWrite |=> perfTarget_r == $past(modelReq.data[15:0]))
    else $error("target register missed a write");
  // a write in the read cycle lands after the answer, so the old target is due
  target_read_a: assert property (
    tgtRead |=> modelRdValid && modelRdData == {48'h0, $past(perfTarget_r)})
    else $error("target read did not return last target");
  move_enable_a: assert property (
    !miscEnable_r[`PSCF_EN_BIT] && !transitionBusy |=> $stable(operatingPoint))
    else $error("point moved while transitions disabled");
  step_size_a: assert property (
    operatingPoint != $past(operatingPoint) |->
      (operatingPoint - $past(operatingPoint) == 16'h0001) ||
      ($past(operatingPoint) - operatingPoint == 16'h0001))
    else $error("point jumped more than one step");
  reach_target_a: assert property (
    miscEnable_r[`PSCF_EN_BIT] && perfTarget_r == operatingPoint + 16'h0001 && !transitionBusy
      ##1 (miscEnable_r[`PSCF_EN_BIT] && $stable(perfTarget_r))[*1]
      |-> ##[0:ReachMax] operatingPoint == perfTarget_r)
    else $error("target not reached in time");
  wrap_both_a: assert property (
    anyWrap && !wrRef && !wrDeliv |=> refCount_r == '0 && delivCount_r == '0)
    else $error("wrap did not clear both counters");
  idle_hold_a: assert property (
    !c0Active && !wrRef && !wrDeliv |=> $stable(refCount_r) && $stable(delivCount_r))
    else $error("counter advanced outside C0");
  ref_count_a: assert property (
    c0Active && !anyWrap && !wrRef |=> refCount_r == $past(refCount_r) + 1'b1)
    else $error("reference counter did not advance");
  write_one_a: assert property (
    wrRef && !wrDeliv && !delivInc && !anyWrap |=> $stable(delivCount_r))
    else $error("write to one counter disturbed the other");
  feed_id_a: assert property (
    idLeaf == `PSCF_LEAF_POWER |=> idEcx[`PSCF_FBK_BIT])
    else $error("feedback counters not reported");
  feat_id_a: assert property (
    idLeaf == `PSCF_LEAF_FEAT |=> idEcx[`PSCF_FEAT_BIT])
    else $error("transition feature not reported");
  throttle_gate_a: assert property (
    thrSync_r && !wrDeliv && !anyWrap |=> $stable(delivCount_r))
    else $error("delivered counter ran while throttled");
endmodule
`default_nettype wire

// *** dv/pscf_sw_model.sv ***
// software-side model issuing model register reads and writes
`timescale 1ns/10ps
`default_nettype none
module pscf_sw_model
  import pscf_pkg::*;
(
  input  wire logic sys_clk,
  output var  pscf_req_s req
);
  initial req = '0;
  // one strobe per access, then an idle cycle
  task automatic acc(input logic w, input logic [31:0] i, input logic [63:0] d);
    @(posedge sys_clk);
    req <= '{wr: w, rd: !w, idx: i, data: d};
    @(posedge sys_clk);
    // released lines show a changed pattern, not the last value
    req <= '{wr: 1'b0, rd: 1'b0, idx: ~i, data: ~d};
  endtask
endmodule
`default_nettype wire

// *** dv/pscf_bench.sv ***
// self-checking bench for the perf-state control block
`timescale 1ns/10ps
`default_nettype none
`include "pscf_params.svh"
module pscf_bench
  import pscf_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  pscf_req_s   modelReq;
  logic [63:0] modelRdData;
  logic        modelRdValid;
  logic [31:0] idLeaf = 32'h0;
  logic [31:0] idEcx;
  logic        c0Active = 1'b0;
  logic        throttlePin = 1'b0;
  pscf_point_t operatingPoint;
  logic        transitionBusy;
  logic [63:0] expQ[$];
  int          errors = 0;
  int          n_tests = 0;
  logic [31:0] rng = 32'd79934;
  pscf_point_t tgt;
  always #2 sys_clk = ~sys_clk;
  pscf_sw_model sw (.sys_clk(sys_clk), .req(modelReq));
  // small counter width so a wrap is reached in a few cycles
  pscf_top #(.CNT_W(8), .DWELL(2)) uut (
    .sys_clk(sys_clk), .nrst(nrst), .modelReq(modelReq), .modelRdData(modelRdData),
    .modelRdValid(modelRdValid), .idLeaf(idLeaf), .idEcx(idEcx), .c0Active(c0Active),
    .throttlePin(throttlePin), .operatingPoint(operatingPoint),
    .transitionBusy(transitionBusy));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic tally_and_finish;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] i, input logic [63:0] d);
    sw.acc(1'b1, i, d);
  endtask
  task automatic rd(input logic [31:0] i, input logic [63:0] e);
    expQ.push_back(e);
    sw.acc(1'b0, i, 64'h0);
  endtask
  task automatic leaf(input logic [31:0] l, input logic [31:0] e);
    @(posedge sys_clk);
    idLeaf <= l;
    cyc(2);
    check({32'h0, e}, {32'h0, idEcx});
  endtask
  task automatic run_c0(input int n);
    @(posedge sys_clk);
    c0Active <= 1'b1;
    repeat (n) @(posedge sys_clk);
    c0Active <= 1'b0;
  endtask
  // oldest noted read result against each answer
  always @(posedge sys_clk) begin
    if (modelRdValid === 1'b1) begin
      // an answer nobody asked for is always a mismatch
      if (expQ.size() == 0) begin
        errors++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, 64'h0, modelRdData);
      end else
        check(expQ.pop_front(), modelRdData);
    end
  end
  initial begin
    #40000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`PSCF_IDX_MISC, 64'h0);
    rd(`PSCF_IDX_TARGET, 64'h0);
    rd(`PSCF_IDX_REF, 64'h0);
    leaf(`PSCF_LEAF_FEAT, 32'h0000_0080);
    leaf(`PSCF_LEAF_POWER, 32'h0000_0001);
    leaf(32'h0000_0005, 32'h0000_0000);
    // target written while disabled must not move the point
    wr(`PSCF_IDX_TARGET, 64'h3);
    cyc(20);
    check(64'h0, {48'h0, operatingPoint});
    rd(`PSCF_IDX_TARGET, 64'h3);
    rd(`PSCF_IDX_CURRENT, 64'h0);
    rng = xs(rng);
    wr(`PSCF_IDX_MISC, {rng, rng} | 64'h1_0000);
    rd(`PSCF_IDX_MISC, {rng, rng} | 64'h1_0000);
    wr(`PSCF_IDX_TARGET, 64'h9);
    cyc(6);
    wr(`PSCF_IDX_TARGET, 64'h2);
    cyc(40);
    check(64'h2, {48'h0, operatingPoint});
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      tgt = {12'h0, rng[3:0]};
      wr(`PSCF_IDX_TARGET, {48'h0, tgt});
      cyc(60);
      check({48'h0, tgt}, {48'h0, operatingPoint});
      check(64'h0, {63'h0, transitionBusy});
      rd(`PSCF_IDX_CURRENT, {48'h0, tgt});
      rd(`PSCF_IDX_TARGET, {48'h0, tgt});
    end
    // current register is read-only, a write must not move the point
    wr(`PSCF_IDX_CURRENT, 64'h5A5A);
    rd(`PSCF_IDX_CURRENT, {48'h0, tgt});
    // counters hold while idle, then the reference wrap in the C0 run clears both
    wr(`PSCF_IDX_REF, 64'hF0);
    wr(`PSCF_IDX_DELIV, 64'h10);
    rd(`PSCF_IDX_REF, 64'hF0);
    rd(`PSCF_IDX_DELIV, 64'h10);
    run_c0(20);
    rd(`PSCF_IDX_REF, 64'h4);
    rd(`PSCF_IDX_DELIV, 64'h4);
    // throttle passes a two-flop sync, so let it settle first
    @(posedge sys_clk);
    throttlePin <= 1'b1;
    wr(`PSCF_IDX_REF, 64'h0);
    wr(`PSCF_IDX_DELIV, 64'h0);
    run_c0(20);
    rd(`PSCF_IDX_REF, 64'h14);
    rd(`PSCF_IDX_DELIV, 64'h0);
    throttlePin <= 1'b0;
    cyc(3);
    check(64'h0, expQ.size());
    tally_and_finish();
  end
endmodule
`default_nettype wire
